/* sscc_channel.sv */
// Synchronous serial channel: APB registers, shift engine and interrupt
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module sscc_channel
   import sscc_pkg::*;
#(
   parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   output logic sdo,
   input wire logic sdi,
   input wire logic ss_n,
   output logic irq
);
   //----------------------------------------------------------------------
   // Declarations
   //----------------------------------------------------------------------
   logic en_q, srst_q, mst_q;
   logic [LEN_W-1:0] len_field_q;
   logic [DATA_W-1:0] txbuf_q, tx_shift_q, rx_shift_q, rxd_q;
   logic [CNT_W-1:0] cnt_q, len;
   logic [DATA_W-1:0] len_mask;
   sscc_cause_type flags_q, inte_q;
   sscc_mst_type state_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q, sdo_q, sclk_q;
   logic [2:0] sck_sync_q, ss_sync_q, sdi_sync_q;
   logic [15:0] div_q;
   logic access, wr, rd, mapped;
   logic wr_ctl, wr_mode, wr_txd, wr_intf, wr_inte, rd_rxd;
   logic sck_s, ss_s, sdi_s, busy;
   logic rise_ev, fall_ev, half_tick, last_bit, frame_done, frame_end, load_ev;
   logic [DATA_W-1:0] rd_word;

   //----------------------------------------------------------------------
   // APB slave
   //----------------------------------------------------------------------
   // Access phase completes on the edge where pready is high
   assign access = psel && penable && pready_q;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign mapped = (paddr == OFF_CTL) || (paddr == OFF_MODE) || (paddr == OFF_TXD) ||
                   (paddr == OFF_RXD) || (paddr == OFF_INTF) || (paddr == OFF_INTE);
   assign wr_ctl = wr && (paddr == OFF_CTL);
   assign wr_mode = wr && (paddr == OFF_MODE);
   assign wr_txd = wr && (paddr == OFF_TXD);
   assign wr_intf = wr && (paddr == OFF_INTF);
   assign wr_inte = wr && (paddr == OFF_INTE);
   assign rd_rxd = rd && (paddr == OFF_RXD);

   // Read multiplexer; reserved bits stay zero
   always_comb begin
      rd_word = '0;
      case (paddr)
         OFF_CTL: begin
            rd_word[CTL_EN_BIT] = en_q;
            rd_word[CTL_SRST_BIT] = srst_q;
         end
         OFF_MODE: begin
            rd_word[MODE_MST_BIT] = mst_q;
            rd_word[MODE_LEN_LSB +: LEN_W] = len_field_q;
         end
         OFF_TXD: rd_word = txbuf_q;
         OFF_RXD: rd_word = rxd_q;
         OFF_INTF: begin
            rd_word[3:0] = flags_q;
            rd_word[INTF_BSY_BIT] = busy;
         end
         OFF_INTE: rd_word[3:0] = inte_q;
         default: rd_word = '0;
      endcase
   end

   // No wait states: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= psel && !penable && !pready_q;
         if (psel && !penable) begin
            pslverr_q <= !mapped;
            prdata_q <= {16'h0000, rd_word};
         end else if (access) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------------
   // Control and mode registers
   //----------------------------------------------------------------------
   // Enable, and soft reset that lasts one cycle then clears itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         srst_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            en_q <= pwdata[CTL_EN_BIT];
         end
         srst_q <= wr_ctl && pwdata[CTL_SRST_BIT];
      end
   end

   // Mode settings change only while the channel is disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_q <= 1'b0;
         len_field_q <= LEN_RST;
      end else if (wr_mode && !en_q) begin
         mst_q <= pwdata[MODE_MST_BIT];
         len_field_q <= pwdata[MODE_LEN_LSB +: LEN_W];
      end
   end

   // Frame length in bits and mask of the bits it covers
   assign len = {1'b0, len_field_q} + 5'h01;
   assign len_mask = 16'hffff >> (5'h10 - len);

   // Transmit buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txbuf_q <= TXD_RST;
      end else if (wr_txd) begin
         txbuf_q <= pwdata[DATA_W-1:0];
      end
   end

   //----------------------------------------------------------------------
   // Pin synchronisers
   //----------------------------------------------------------------------
   // Two flops before use; the third flop feeds the edge detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_sync_q <= 3'h0;
         ss_sync_q <= 3'h7;
         sdi_sync_q <= 3'h0;
      end else begin
         sck_sync_q <= {sck_sync_q[1:0], sclk_in};
         ss_sync_q <= {ss_sync_q[1:0], ss_n};
         sdi_sync_q <= {sdi_sync_q[1:0], sdi};
      end
   end
   assign sck_s = sck_sync_q[1];
   assign ss_s = ss_sync_q[1];
   assign sdi_s = sdi_sync_q[1];

   //----------------------------------------------------------------------
   // Serial clock generation and edge events
   //----------------------------------------------------------------------
   // Master clock runs only while enabled in master mode and busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
         sclk_q <= 1'b0;
      end else if (en_q && mst_q && state_q == M_RUN && !srst_q) begin
         if (half_tick) begin
            div_q <= '0;
            sclk_q <= !sclk_q;
         end else begin
            div_q <= div_q + 16'h0001;
         end
      end else begin
         div_q <= '0;
         sclk_q <= 1'b0;
      end
   end
   assign half_tick = (div_q == 16'(HALF_CYC - 1));

   // Sample on rising edges, shift on falling edges, in either mode
   always_comb begin
      if (mst_q) begin
         rise_ev = en_q && state_q == M_RUN && half_tick && !sclk_q && !srst_q;
         fall_ev = en_q && state_q == M_RUN && half_tick && sclk_q && !srst_q;
      end else begin
         rise_ev = en_q && !ss_s && sck_sync_q[1] && !sck_sync_q[2] && !srst_q;
         fall_ev = en_q && !ss_s && !sck_sync_q[1] && sck_sync_q[2] && !srst_q;
      end
   end

   assign last_bit = (cnt_q + 5'h01 == len);
   assign frame_done = rise_ev && last_bit;
   assign frame_end = fall_ev && (cnt_q == len);
   // Load the shifter from the buffer when a word is waiting
   always_comb begin
      if (mst_q) begin
         load_ev = en_q && !srst_q && !flags_q.tbe && ((state_q == M_IDLE) || frame_end);
      end else begin
         load_ev = en_q && !srst_q && !flags_q.tbe && cnt_q == '0 && !rise_ev;
      end
   end
   assign busy = mst_q ? (state_q == M_RUN) : (en_q && !ss_s);

   //----------------------------------------------------------------------
   // Shift engine
   //----------------------------------------------------------------------
   // Master sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= M_IDLE;
      end else if (!en_q || !mst_q || srst_q) begin
         state_q <= M_IDLE;
      end else if (load_ev) begin
         state_q <= M_RUN;
      end else if (frame_end) begin
         state_q <= M_IDLE;
      end
   end

   // Bit counter and shift registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         tx_shift_q <= '0;
         rx_shift_q <= '0;
      end else if (srst_q) begin
         cnt_q <= '0;
         tx_shift_q <= '0;
         rx_shift_q <= '0;
      end else if (!en_q || (!mst_q && ss_s)) begin
         cnt_q <= '0;
      end else begin
         if (load_ev) begin
            tx_shift_q <= txbuf_q;
         end else if (fall_ev && cnt_q != len) begin
            tx_shift_q <= {tx_shift_q[DATA_W-2:0], 1'b0};
         end
         if (rise_ev) begin
            rx_shift_q <= {rx_shift_q[DATA_W-2:0], sdi_s};
            cnt_q <= cnt_q + 5'h01;
         end else if (frame_end || load_ev) begin
            cnt_q <= '0;
         end
      end
   end

   // Only the bit at index len_field_q, one below the frame length, reaches the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= tx_shift_q[len_field_q];
      end
   end

   //----------------------------------------------------------------------
   // Receive data register
   //----------------------------------------------------------------------
   // Stores masked frames; cleared by enable or soft reset writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_q <= RXD_RST;
      end else if (wr_ctl && (pwdata[CTL_EN_BIT] || pwdata[CTL_SRST_BIT])) begin
         rxd_q <= RXD_RST;
      end else if (frame_done) begin
         rxd_q <= {rx_shift_q[DATA_W-2:0], sdi_s} & len_mask;
      end
   end

   //----------------------------------------------------------------------
   // Interrupt flags, enables and request
   //----------------------------------------------------------------------
   // Hardware set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= CAUSE_RST;
      end else begin
         if (frame_done && flags_q.rbf) begin
            flags_q.oe <= 1'b1;
         end else if (wr_intf && pwdata[3]) begin
            flags_q.oe <= 1'b0;
         end
         if (frame_end && (flags_q.tbe || load_ev == 1'b0 && !mst_q && flags_q.tbe)) begin
            flags_q.tend <= 1'b1;
         end else if (wr_intf && pwdata[2]) begin
            flags_q.tend <= 1'b0;
         end
         if (frame_done) begin
            flags_q.rbf <= 1'b1;
         end else if (rd_rxd) begin
            flags_q.rbf <= 1'b0;
         end
         if (load_ev) begin
            flags_q.tbe <= 1'b1;
         end else if (wr_txd) begin
            flags_q.tbe <= 1'b0;
         end
      end
   end

   // Per-cause enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inte_q <= ENABLE_RST;
      end else if (wr_inte) begin
         inte_q <= pwdata[3:0];
      end
   end

   // Level request while any enabled cause is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & inte_q);
      end
   end

   //----------------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------------
   logic sclk_oe_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_oe_q <= 1'b0;
      end else begin
         sclk_oe_q <= en_q && mst_q;
      end
   end
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sclk_out = sclk_q;
   assign sclk_oe = sclk_oe_q;
   assign sdo = sdo_q;
   assign irq = irq_q;

   //----------------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_srst_self_clear: assert property (wr_ctl && pwdata[CTL_SRST_BIT] |=> srst_q ##1 !srst_q && cnt_q == '0)
      else $error("soft reset did not clear itself");
   a_master_clock_off: assert property (!en_q |=> !sclk_q [*2])
      else $error("master clock runs while disabled");
   a_master_start: assert property (en_q && mst_q && state_q == M_IDLE && !flags_q.tbe && !srst_q
      |=> state_q == M_RUN && flags_q.tbe)
      else $error("transmit write did not start master transfer");
   a_rxd_masked: assert property ((rxd_q & ~len_mask) == '0)
      else $error("receive bits above frame length not zero");
   a_rxd_clear: assert property (wr_ctl && pwdata[CTL_EN_BIT] |=> rxd_q == RXD_RST)
      else $error("receive data not cleared on enable write");
   a_busy_slave: assert property (!mst_q && en_q && !ss_s |-> busy)
      else $error("busy low while slave selected");
   a_tend_sticky: assert property (flags_q.tend && !(wr_intf && pwdata[2]) |=> flags_q.tend)
      else $error("transmit end flag lost without clear");
   a_rbf_read_clear: assert property (rd_rxd && !frame_done |=> !flags_q.rbf)
      else $error("receive full not cleared by read");
   a_tbe_write_clear: assert property (wr_txd && !load_ev |=> !flags_q.tbe)
      else $error("transmit empty not cleared by write");
   a_irq_level: assert property ((flags_q & inte_q) != 4'h0 |=> irq_q)
      else $error("interrupt missing for enabled cause");
   a_overrun_set: assert property (frame_done && flags_q.rbf |=> flags_q.oe && flags_q.rbf)
      else $error("overrun not flagged");
endmodule : sscc_channel

/* sscc_channel_tb.sv */
// Self-checking testbench of the synchronous serial channel
`timescale 1ns/1ps
module sscc_channel_tb
   import sscc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, ss_n, pload, slv_sclk;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, sclk_out, sclk_oe, sdo, sdi, irq, err;
   logic [15:0] got_word;
   int bad_count = 0;
   int cmp_count = 0;

   sscc_channel i_sscc_channel (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_in(slv_sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo(sdo),
      .sdi(sdi), .ss_n(ss_n), .irq(irq));
   sscc_spi_partner i_sscc_spi_partner (.sclk(sclk_out), .mosi(sdo), .miso(sdi), .load(pload),
      .load_word(16'ha55a), .got_word(got_word));

   // Clock at 25 MHz
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   //----------------------------------------------------------------------
   // Report and compare helpers
   //----------------------------------------------------------------------
   task automatic give_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   //----------------------------------------------------------------------
   // APB master: setup, then access held until pready is sampled high
   //----------------------------------------------------------------------
   task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         give_verdict();
      end
   endtask : apb_xfer

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      apb_xfer(1'b1, a, wd);
   endtask : wr

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      apb_xfer(1'b0, a, 32'h0000_0000);
      chk_word(rd, exp);
   endtask : rd_chk

   // Read the flag register until the chosen bit is set, bounded
   task automatic poll_flag(input int b);
      int n;
      n = 0;
      do begin
         apb_xfer(1'b0, OFF_INTF, 32'h0000_0000);
         n++;
      end while (rd[b] !== 1'b1 && n < 100);
      if (n >= 100) begin
         bad_count++;
         give_verdict();
      end
   endtask : poll_flag
   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   task automatic reset_values;
      rd_chk(OFF_CTL, 32'h0000_0000);
      rd_chk(OFF_MODE, 32'h0000_0700);
      rd_chk(OFF_TXD, 32'h0000_0000);
      rd_chk(OFF_RXD, 32'h0000_0000);
      rd_chk(OFF_INTF, 32'h0000_0001);
      rd_chk(OFF_INTE, 32'h0000_0000);
      apb_xfer(1'b0, 8'h40, 32'h0000_0000);
      chk_bit(err, 1'b1);
      chk_word(rd, 32'h0000_0000);
   endtask : reset_values

   task automatic reserved_bits;
      wr(OFF_INTE, 32'h0000_ffff);
      rd_chk(OFF_INTE, 32'h0000_000f);
      wr(OFF_CTL, 32'h0000_fffc);
      rd_chk(OFF_CTL, 32'h0000_0000);
   endtask : reserved_bits

   // Only transmit empty is set here, so only its enable may raise irq
   task automatic irq_mask;
      wr(OFF_INTE, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b0);
      wr(OFF_INTE, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b1);
      wr(OFF_INTE, 32'h0000_000e);
      repeat (3) @(posedge pclk);
      chk_bit(irq, 1'b0);
   endtask : irq_mask

   // Two 8-bit words back to back, the first left unread to force overrun
   task automatic master_stream;
      wr(OFF_MODE, 32'h0000_0701);
      wr(OFF_CTL, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      chk_bit(sclk_oe, 1'b1);
      rd_chk(OFF_CTL, 32'h0000_0001);
      @(posedge pclk);
      pload <= 1'b1;
      @(posedge pclk);
      pload <= 1'b0;
      wr(OFF_TXD, 32'h0000_01c3);
      poll_flag(0);
      chk_bit(rd[INTF_BSY_BIT], 1'b1);
      wr(OFF_TXD, 32'h0000_025a);
      poll_flag(2);
      chk_word({16'h0000, got_word}, 32'h0000_c35a);
      rd_chk(OFF_INTF, 32'h0000_000f);
      wr(OFF_INTF, 32'h0000_0000);
      rd_chk(OFF_INTF, 32'h0000_000f);
      wr(OFF_INTF, 32'h0000_000c);
      rd_chk(OFF_INTF, 32'h0000_0003);
      rd_chk(OFF_RXD, 32'h0000_005a);
      rd_chk(OFF_INTF, 32'h0000_0001);
      wr(OFF_CTL, 32'h0000_0001);
      rd_chk(OFF_RXD, 32'h0000_0000);
   endtask : master_stream

   // Slave mode: busy follows the select input; one 8-bit frame of ones is clocked in
   task automatic slave_busy;
      wr(OFF_CTL, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk_bit(sclk_oe, 1'b0);
      wr(OFF_MODE, 32'h0000_0700);
      wr(OFF_CTL, 32'h0000_0003);
      ss_n <= 1'b0;
      pload <= 1'b1;
      repeat (4) @(posedge pclk);
      pload <= 1'b0;
      apb_xfer(1'b0, OFF_INTF, 32'h0000_0000);
      chk_bit(rd[INTF_BSY_BIT], 1'b1);
      // Link clock of 320 ns, idle low; the partner holds its data line high
      repeat (8) begin
         slv_sclk <= 1'b1;
         repeat (4) @(posedge pclk);
         slv_sclk <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      poll_flag(1);
      rd_chk(OFF_INTF, 32'h0000_0087);
      rd_chk(OFF_RXD, 32'h0000_00ff);
      ss_n <= 1'b1;
      repeat (4) @(posedge pclk);
      apb_xfer(1'b0, OFF_INTF, 32'h0000_0000);
      chk_bit(rd[INTF_BSY_BIT], 1'b0);
   endtask : slave_busy
   //----------------------------------------------------------------------
   // Main sequence and watchdog
   //----------------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      ss_n = 1'b1;
      pload = 1'b0;
      slv_sclk = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      reserved_bits();
      irq_mask();
      master_stream();
      slave_busy();
      give_verdict();
   end

   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      give_verdict();
   end
endmodule : sscc_channel_tb

/* sscc_pkg.sv */
// Constants, field layouts and types of the synchronous serial channel
package sscc_pkg;
   //----------------------------------------------------------------------
   // Register map, byte offsets
   //----------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CTL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_TXD = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RXD = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_INTF = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_INTE = 8'h14;
   //----------------------------------------------------------------------
   // Field positions and reset values
   //----------------------------------------------------------------------
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CTL_EN_BIT = 0;
   localparam int unsigned CTL_SRST_BIT = 1;
   localparam int unsigned MODE_MST_BIT = 0;
   localparam int unsigned MODE_LEN_LSB = 8;
   localparam int unsigned LEN_W = 4;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned INTF_BSY_BIT = 7;
   localparam logic [LEN_W-1:0] LEN_RST = 4'h7;
   localparam logic [DATA_W-1:0] TXD_RST = 16'h0000;
   localparam logic [DATA_W-1:0] RXD_RST = 16'h0000;
   //----------------------------------------------------------------------
   // Timing: half period of the master serial clock
   //----------------------------------------------------------------------
   localparam int unsigned PCLK_NS = 40;
   localparam int unsigned SCLK_HALF_NS = 160;
   localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
   //----------------------------------------------------------------------
   // Types
   //----------------------------------------------------------------------
   typedef struct packed {
      logic oe;
      logic tend;
      logic rbf;
      logic tbe;
   } sscc_cause_type;
   localparam sscc_cause_type CAUSE_RST = 4'h1;
   localparam sscc_cause_type ENABLE_RST = 4'h0;
   typedef enum logic {M_IDLE, M_RUN} sscc_mst_type;
endpackage : sscc_pkg

/* sscc_spi_partner.sv */
// Behavioural SPI slave that faces the channel while it runs as master
`timescale 1ns/1ps
module sscc_spi_partner (
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   input wire logic load,
   input wire logic [15:0] load_word,
   output logic [15:0] got_word
);
   logic [15:0] sreg_q;
   //----------------------------------------------------------------------
   // Shift engine, mode 0, most significant bit first
   //----------------------------------------------------------------------
   // Shift out on the falling edge; spent bits are refilled with the inverse
   // so a master that samples too late never sees a stale copy
   always_ff @(negedge sclk or posedge load) begin
      if (load) begin
         sreg_q <= load_word;
      end else begin
         sreg_q <= {sreg_q[14:0], ~sreg_q[15]};
      end
   end
   // Capture the master's data on the rising edge
   always_ff @(posedge sclk or posedge load) begin
      if (load) begin
         got_word <= 16'h0000;
      end else begin
         got_word <= {got_word[14:0], mosi};
      end
   end
   assign miso = sreg_q[15];
endmodule : sscc_spi_partner
